/* verilog/io_register_space_decoder.sv */
// Purpose : decodes core i/o reads and writes onto the i/o register space
// Assumes : core strobes and operands are on ref_clk; hub line states are pins
// Notes   : read data appears one cycle after the read strobe with rd_valid
//
// Operation
// [RULE_01] read returns addressed register into accumulator
// [RULE_02] direct write stores accumulator at instruction address
// [RULE_03] indexed write targets address field plus index
// [RULE_04] zero address field selects by index alone
// [RULE_05] firmware never writes unassigned addresses
// [RULE_06] firmware writes zero into reserved bits
// [RULE_07] timer read as low byte, upper nibble
// [RULE_08] vector read returns vector, clears pending
// [RULE_09] gpio pin interrupt masks are write-only
// [RULE_10] five-endpoint mode: b setups configure a3, a4
// [RULE_11] five-endpoint mode ignores second device address
// [RULE_12] hub resume, se0, line data read-only live
// [RULE_13] watchdog kick write-only, restarts interval
// [RULE_14] low timer read latches upper nibble
// [RULE_15] unassigned addresses: writes ignored, reads zero
// [RULE_16] read-only ignore writes, write-only read zero

`timescale 1ns/10ps
`default_nettype none

module io_register_space_decoder (
   // clock and reset
   input  wire logic                                           ref_clk,
   input  wire logic                                           rst_n,
   // core i/o instruction port
   input  wire io_space_pkg::core_req_t                        core_req,
   output logic [7:0]                                          rd_data,
   output logic                                                rd_valid,
   // interrupt controller
   input  wire logic [7:0]                                     irq_vector,
   output logic                                                irq_ack,
   // watchdog
   output logic                                                watchdog_restart,
   // usb function setup
   input  wire logic                                           five_ep_mode,
   output logic [7:0]                                          func_a_ep3_setup,
   output logic [7:0]                                          func_a_ep4_setup,
   output logic                                                func_b_addr_active,
   // hub downstream live line states, from pins
   input  wire io_space_pkg::hub_lines_t                       hub_lines,
   // stored register values to the peripherals
   output logic [io_space_pkg::NSLOT-1:0][7:0]                 slot_value
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   io_space_pkg::io_state_t st;
   io_space_pkg::io_state_t next_st;
   logic [7:0]              xaddr;
   logic [5:0]              wslot;
   logic [5:0]              xslot;
   logic [5:0]              rslot;

   // a miss returns NSLOT, which no slot index reaches
   function automatic logic [5:0] slot_of(input logic [7:0] a);
      slot_of = 6'(io_space_pkg::NSLOT);
      for (int i = 0; i < io_space_pkg::NSLOT; i++) begin
         if (io_space_pkg::SLOT_ADDR[i] == a) begin
            slot_of = 6'(i);
         end
      end
   endfunction

   // ------------------------------------------------------------
   // address forming
   // ------------------------------------------------------------
   // the sum wraps at 8 bits; a zero field leaves the index alone
   assign xaddr = core_req.addr + core_req.index_x; // [RULE_03] [RULE_04]
   assign wslot = slot_of(core_req.addr);
   assign xslot = slot_of(xaddr);
   assign rslot = slot_of(core_req.addr);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.rd_valid = 1'b0;
      next_st.irq_ack  = 1'b0;
      next_st.wd_kick  = 1'b0;
      // two stages before any read of the live line states
      next_st.sync1    = hub_lines;
      next_st.sync2    = st.sync1;

      // 1 us tick from the 50 MHz clock
      if (st.prescale == 6'(io_space_pkg::TICK_CYCLES - 1)) begin
         next_st.prescale = 6'h00;
         next_st.timer    = st.timer + io_space_pkg::TIMER_STEP;
      end else begin
         next_st.prescale = st.prescale + 6'h01;
      end

      // direct write; addresses outside the slot map store nothing
      if (core_req.port_write_instr) begin
         if (wslot < 6'(io_space_pkg::NSLOT)) begin
            next_st.slot[wslot] = core_req.acc; // [RULE_02] [RULE_15] [RULE_16]
         end
         if (core_req.addr == io_space_pkg::ADDR_WD_KICK) begin
            next_st.wd_kick = 1'b1; // [RULE_13]
         end
      end

      // indexed write; wins over a direct write in the same cycle
      if (core_req.indexed_port_write_instr) begin
         if (xslot < 6'(io_space_pkg::NSLOT)) begin
            next_st.slot[xslot] = core_req.acc; // [RULE_03] [RULE_04] [RULE_15]
         end
         if (xaddr == io_space_pkg::ADDR_WD_KICK) begin
            next_st.wd_kick = 1'b1; // [RULE_13]
         end
      end

      // read decode
      if (core_req.port_read_instr) begin
         next_st.rd_valid = 1'b1; // [RULE_01]
         next_st.rd_data  = io_space_pkg::RESET_BYTE;
         if (core_req.addr == io_space_pkg::ADDR_IRQ_VECTOR) begin
            next_st.rd_data = irq_vector; // [RULE_08]
            next_st.irq_ack = 1'b1; // [RULE_08]
         end else if (core_req.addr == io_space_pkg::ADDR_TIMER_LOW) begin
            next_st.rd_data    = st.timer[7:0]; // [RULE_07]
            next_st.timer_hold = st.timer[11:8]; // [RULE_14]
         end else if (core_req.addr == io_space_pkg::ADDR_TIMER_HIGH) begin
            next_st.rd_data = {4'h0, st.timer_hold}; // [RULE_07] [RULE_14]
         end else if (core_req.addr == io_space_pkg::ADDR_DS_RESUME) begin
            next_st.rd_data = st.sync2.resume; // [RULE_12]
         end else if (core_req.addr == io_space_pkg::ADDR_DS_SE0) begin
            next_st.rd_data = st.sync2.single_ended_zero; // [RULE_12]
         end else if (core_req.addr == io_space_pkg::ADDR_DS_LINE_DATA) begin
            next_st.rd_data = st.sync2.line_data; // [RULE_12]
         end else if (rslot >= 6'(io_space_pkg::FIRST_READABLE)
                      && rslot < 6'(io_space_pkg::NSLOT)) begin
            next_st.rd_data = st.slot[rslot]; // [RULE_01]
         end
         // gpio pin interrupt masks, watchdog kick and unassigned space read zero
         // [RULE_09] [RULE_15] [RULE_16]
      end

      // in five-endpoint mode the b setups steer endpoints a3 and a4
      if (five_ep_mode) begin
         next_st.a_ep3_setup   = next_st.slot[io_space_pkg::SLOT_B_EP0]; // [RULE_10]
         next_st.a_ep4_setup   = next_st.slot[io_space_pkg::SLOT_B_EP1]; // [RULE_10]
         next_st.b_addr_active = 1'b0; // [RULE_11]
      end else begin
         next_st.a_ep3_setup   = io_space_pkg::RESET_BYTE;
         next_st.a_ep4_setup   = io_space_pkg::RESET_BYTE;
         next_st.b_addr_active = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rd_data            = st.rd_data;
   assign rd_valid           = st.rd_valid;
   assign irq_ack            = st.irq_ack;
   assign watchdog_restart   = st.wd_kick;
   assign func_a_ep3_setup   = st.a_ep3_setup;
   assign func_a_ep4_setup   = st.a_ep4_setup;
   assign func_b_addr_active = st.b_addr_active;
   assign slot_value         = st.slot;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_read_answer: assert property ( // [RULE_01]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_read_instr |=> rd_valid ##1 !rd_valid || $past(core_req.port_read_instr))
      else $error("read strobe not answered next cycle");

   a_direct_write: assert property ( // [RULE_02]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_write_instr && !core_req.indexed_port_write_instr
      && core_req.addr == io_space_pkg::ADDR_GPIO_SETUP
      |=> slot_value[4] == $past(core_req.acc))
      else $error("direct write did not store accumulator");

   a_indexed_write: assert property ( // [RULE_03]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.indexed_port_write_instr && xaddr == io_space_pkg::ADDR_P1_VALUE
      |=> slot_value[3] == $past(core_req.acc))
      else $error("indexed write missed summed address");

   a_index_only: assert property ( // [RULE_04]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.indexed_port_write_instr && core_req.addr == 8'h00
      && core_req.index_x == io_space_pkg::ADDR_P0_VALUE
      |=> slot_value[2] == $past(core_req.acc))
      else $error("zero field write not selected by index");

   a_timer_latch: assert property ( // [RULE_14]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_read_instr && core_req.addr == io_space_pkg::ADDR_TIMER_LOW
      ##1 core_req.port_read_instr && core_req.addr == io_space_pkg::ADDR_TIMER_HIGH
      |=> rd_data == {4'h0, $past(st.timer[11:8], 2)})
      else $error("upper timer nibble not taken from low read");

   a_vector_ack: assert property ( // [RULE_08]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_read_instr && core_req.addr == io_space_pkg::ADDR_IRQ_VECTOR
      |=> irq_ack && rd_data == $past(irq_vector))
      else $error("vector read did not return and clear");

   a_mask_wo: assert property ( // [RULE_09]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_read_instr && core_req.addr == io_space_pkg::ADDR_P1_IRQ_MASK
      |=> rd_data == 8'h00)
      else $error("write-only mask read back nonzero");

   a_wd_kick: assert property ( // [RULE_13]
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(watchdog_restart) |-> $past(
         (core_req.port_write_instr && core_req.addr == io_space_pkg::ADDR_WD_KICK)
         || (core_req.indexed_port_write_instr && xaddr == io_space_pkg::ADDR_WD_KICK)))
      else $error("watchdog restart without a kick write");

   a_ep_remap: assert property ( // [RULE_10]
      @(posedge ref_clk) disable iff (!rst_n)
      five_ep_mode |=> func_a_ep3_setup == slot_value[io_space_pkg::SLOT_B_EP0]
      && func_a_ep4_setup == slot_value[io_space_pkg::SLOT_B_EP1])
      else $error("b setups not mapped to a3 and a4");

   a_b_addr_off: assert property ( // [RULE_11]
      @(posedge ref_clk) disable iff (!rst_n)
      five_ep_mode |=> !func_b_addr_active)
      else $error("second address active in five-endpoint mode");

   a_rsvd_zero: assert property ( // [RULE_15]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_read_instr && core_req.addr[7:3] == 5'h07
      |=> rd_data == 8'h00)
      else $error("reserved read returned nonzero");

   a_line_live: assert property ( // [RULE_12]
      @(posedge ref_clk) disable iff (!rst_n)
      core_req.port_read_instr && core_req.addr == io_space_pkg::ADDR_DS_SE0
      |=> rd_data == $past(hub_lines.single_ended_zero, 3))
      else $error("se0 state read not from synchronised lines");

endmodule

`default_nettype wire

/* verilog/io_space_pkg.sv */
// Purpose : constants, slot map and carrier types of the i/o register space
// Assumes : 8-bit port addresses, one i/o instruction per core cycle
// Notes   : writable storage is a flat slot array; the slot map ties slots to addresses

package io_space_pkg;

   // ------------------------------------------------------------
   // port addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_P0_VALUE      = 8'h00;
   localparam logic [7:0] ADDR_P1_VALUE      = 8'h01;
   localparam logic [7:0] ADDR_P0_IRQ_MASK   = 8'h04;
   localparam logic [7:0] ADDR_P1_IRQ_MASK   = 8'h05;
   localparam logic [7:0] ADDR_GPIO_SETUP    = 8'h08;
   localparam logic [7:0] ADDR_TW_PIN_SETUP  = 8'h09;
   localparam logic [7:0] ADDR_A_ADDRESS     = 8'h10;
   localparam logic [7:0] ADDR_A_EP0_COUNT   = 8'h11;
   localparam logic [7:0] ADDR_A_EP0_SETUP   = 8'h12;
   localparam logic [7:0] ADDR_A_EP1_COUNT   = 8'h13;
   localparam logic [7:0] ADDR_A_EP1_SETUP   = 8'h14;
   localparam logic [7:0] ADDR_A_EP2_COUNT   = 8'h15;
   localparam logic [7:0] ADDR_A_EP2_SETUP   = 8'h16;
   localparam logic [7:0] ADDR_UP_TRAFFIC    = 8'h1F;
   localparam logic [7:0] ADDR_GLOBAL_IRQ    = 8'h20;
   localparam logic [7:0] ADDR_EP_IRQ_MASK   = 8'h21;
   localparam logic [7:0] ADDR_IRQ_VECTOR    = 8'h23;
   localparam logic [7:0] ADDR_TIMER_LOW     = 8'h24;
   localparam logic [7:0] ADDR_TIMER_HIGH    = 8'h25;
   localparam logic [7:0] ADDR_WD_KICK       = 8'h26;
   localparam logic [7:0] ADDR_TW_CTRL       = 8'h28;
   localparam logic [7:0] ADDR_TW_BYTE       = 8'h29;
   localparam logic [7:0] ADDR_B_ADDRESS     = 8'h40;
   localparam logic [7:0] ADDR_B_EP0_COUNT   = 8'h41;
   localparam logic [7:0] ADDR_B_EP0_SETUP   = 8'h42;
   localparam logic [7:0] ADDR_B_EP1_COUNT   = 8'h43;
   localparam logic [7:0] ADDR_B_EP1_SETUP   = 8'h44;
   localparam logic [7:0] ADDR_DS_ATTACH     = 8'h48;
   localparam logic [7:0] ADDR_DS_ENABLE     = 8'h49;
   localparam logic [7:0] ADDR_DS_SPEED      = 8'h4A;
   localparam logic [7:0] ADDR_DS_LINE_CTRL  = 8'h4B;
   localparam logic [7:0] ADDR_DS_SUSPEND    = 8'h4D;
   localparam logic [7:0] ADDR_DS_RESUME     = 8'h4E;
   localparam logic [7:0] ADDR_DS_SE0        = 8'h4F;
   localparam logic [7:0] ADDR_DS_LINE_DATA  = 8'h50;
   localparam logic [7:0] ADDR_DS_DRIVE_LOW  = 8'h51;
   localparam logic [7:0] ADDR_CPU_STATE     = 8'hFF;

   // ------------------------------------------------------------
   // slot map: slots below FIRST_READABLE are write-only
   // ------------------------------------------------------------
   localparam int NSLOT          = 30;
   localparam int FIRST_READABLE = 2;
   localparam int SLOT_B_ADDRESS = 18;
   localparam int SLOT_B_EP0     = 20;
   localparam int SLOT_B_EP1     = 22;
   localparam logic [NSLOT-1:0][7:0] SLOT_ADDR = {
      ADDR_CPU_STATE, ADDR_DS_DRIVE_LOW, ADDR_DS_SUSPEND, ADDR_DS_LINE_CTRL,
      ADDR_DS_SPEED, ADDR_DS_ENABLE, ADDR_DS_ATTACH, ADDR_B_EP1_SETUP,
      ADDR_B_EP1_COUNT, ADDR_B_EP0_SETUP, ADDR_B_EP0_COUNT, ADDR_B_ADDRESS,
      ADDR_TW_BYTE, ADDR_TW_CTRL, ADDR_EP_IRQ_MASK, ADDR_GLOBAL_IRQ,
      ADDR_UP_TRAFFIC, ADDR_A_EP2_SETUP, ADDR_A_EP2_COUNT, ADDR_A_EP1_SETUP,
      ADDR_A_EP1_COUNT, ADDR_A_EP0_SETUP, ADDR_A_EP0_COUNT, ADDR_A_ADDRESS,
      ADDR_TW_PIN_SETUP, ADDR_GPIO_SETUP, ADDR_P1_VALUE, ADDR_P0_VALUE,
      ADDR_P1_IRQ_MASK, ADDR_P0_IRQ_MASK};

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int TIMER_TICK_NS = 1000;
   localparam int TICK_CYCLES   = TIMER_TICK_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  RESET_BYTE  = 8'h00;
   localparam logic [11:0] TIMER_STEP  = 12'h001;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       port_read_instr;
      logic       port_write_instr;
      logic       indexed_port_write_instr;
      logic [7:0] addr;
      logic [7:0] index_x;
      logic [7:0] acc;
   } core_req_t;

   typedef struct packed {
      logic [7:0] resume;
      logic [7:0] single_ended_zero;
      logic [7:0] line_data;
   } hub_lines_t;

   typedef struct packed {
      logic [NSLOT-1:0][7:0] slot;
      logic [11:0]           timer;
      logic [5:0]            prescale;
      logic [3:0]            timer_hold;
      logic [7:0]            rd_data;
      logic                  rd_valid;
      logic                  irq_ack;
      logic                  wd_kick;
      hub_lines_t            sync1;
      hub_lines_t            sync2;
      logic [7:0]            a_ep3_setup;
      logic [7:0]            a_ep4_setup;
      logic                  b_addr_active;
   } io_state_t;

endpackage

/* tb/core_io_model.sv */
// Purpose : core model issuing i/o read, write and indexed write
// Assumes : one instruction per call, strobe high for one cycle
// Notes   : idle operands show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none

module core_io_model (
   // clock
   input  wire logic                   ref_clk,
   // core port
   output var io_space_pkg::core_req_t core_req,
   input  wire logic [7:0]             rd_data,
   input  wire logic                   rd_valid
);
   // --------------------
   // instruction issue
   // --------------------
   logic rsvd_ok = 1'b0;

   initial core_req = '0;

   function automatic logic mapped(input logic [7:0] a);
      mapped = a inside {8'h23, 8'h24, 8'h25, 8'h26, 8'h4E, 8'h4F, 8'h50};
      for (int i = 0; i < io_space_pkg::NSLOT; i++) begin
         mapped |= (io_space_pkg::SLOT_ADDR[i] == a);
      end
   endfunction

   // kind is {read, write, indexed}; a skipped write answers nothing
   task automatic issue(input logic [2:0] kind, input logic [7:0] a, input logic [7:0] x,
                        input logic [7:0] d, output logic [7:0] q, output logic v);
      logic [7:0] t;
      t = kind[0] ? a + x : a;
      q = 8'h00;
      v = 1'b0;
      if (kind[2] || rsvd_ok || mapped(t)) begin
         @(posedge ref_clk);
         core_req <= {kind, a, x, d};
         @(posedge ref_clk);
         core_req <= {3'b000, ~a, ~x, ~d};
         #1;
         q = rd_data;
         v = rd_valid;
      end
   endtask
endmodule
`default_nettype wire

/* tb/io_register_space_decoder_tb_top.sv */
// Purpose : self-checking bench of the i/o register space decoder
// Assumes : core model issues one instruction per call
// Notes   : a byte-array model of the map predicts every read except the timer, and every slot
`timescale 1ns/10ps
`default_nettype none

module io_register_space_decoder_tb_top;
   // --------------------
   // signals
   // --------------------
   logic                                ref_clk;
   logic                                rst_n;
   io_space_pkg::core_req_t             core_req;
   logic [7:0]                          rd_data;
   logic                                rd_valid;
   logic [7:0]                          irq_vector;
   logic                                irq_ack;
   logic                                watchdog_restart;
   logic                                five_ep_mode;
   logic [7:0]                          ep3;
   logic [7:0]                          ep4;
   logic                                b_active;
   io_space_pkg::hub_lines_t            hub_lines;
   logic [io_space_pkg::NSLOT-1:0][7:0] slot_value;
   int                                  bad_count = 0;
   int                                  total_checks = 0;
   int                                  cyc = 0;
   logic [31:0]                         seed = 32'h2415;
   logic [7:0]                          mem [256];
   logic [7:0]                          q;
   logic                                v;

   core_io_model u_core_io_model (.ref_clk(ref_clk), .core_req(core_req),
      .rd_data(rd_data), .rd_valid(rd_valid));

   io_register_space_decoder u_io_register_space_decoder (.ref_clk(ref_clk),
      .rst_n(rst_n), .core_req(core_req), .rd_data(rd_data), .rd_valid(rd_valid),
      .irq_vector(irq_vector), .irq_ack(irq_ack), .watchdog_restart(watchdog_restart),
      .five_ep_mode(five_ep_mode), .func_a_ep3_setup(ep3), .func_a_ep4_setup(ep4),
      .func_b_addr_active(b_active), .hub_lines(hub_lines), .slot_value(slot_value));

   // --------------------
   // reference model
   // --------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic int slot_of(input logic [7:0] a);
      slot_of = -1;
      for (int i = 0; i < io_space_pkg::NSLOT; i++) begin
         if (io_space_pkg::SLOT_ADDR[i] == a) begin
            slot_of = i;
         end
      end
   endfunction

   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h23: exp_rd = irq_vector;
         8'h4E: exp_rd = hub_lines.resume;
         8'h4F: exp_rd = hub_lines.single_ended_zero;
         8'h50: exp_rd = hub_lines.line_data;
         default: exp_rd = (slot_of(a) >= io_space_pkg::FIRST_READABLE) ? mem[a] : 8'h00;
      endcase
   endfunction

   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_flag(input string what, input logic e, input logic g);
      chk_byte(what, {7'h00, e}, {7'h00, g});
   endtask

   // --------------------
   // transfers
   // --------------------
   task automatic rd(input logic [7:0] a);
      u_core_io_model.issue(3'b100, a, 8'h00, 8'h00, q, v);
      chk_flag("rd_valid", 1'b1, v);
      chk_flag("irq_ack", a == 8'h23, irq_ack);
      if (a != 8'h24 && a != 8'h25) begin
         chk_byte("rd_data", exp_rd(a), q);
      end
   endtask

   task automatic wr(input logic ix, input logic [7:0] a, input logic [7:0] x);
      logic [7:0] d;
      logic [7:0] t;
      seed = lfsr(seed);
      d = seed[7:0];
      t = ix ? a + x : a;
      u_core_io_model.issue({1'b0, !ix, ix}, a, x, d, q, v);
      if (slot_of(t) >= 0) begin
         mem[t] = d;
      end
      chk_flag("watchdog_restart", t == 8'h26, watchdog_restart);
      chk_flag("rd_valid_on_write", 1'b0, v);
   endtask

   task automatic sweep();
      seed = lfsr(seed);
      irq_vector <= seed[7:0];
      hub_lines <= seed[31:8];
      repeat (3) @(posedge ref_clk);
      for (int a = 0; a < 256; a++) begin
         rd(a[7:0]);
      end
      for (int i = 0; i < io_space_pkg::NSLOT; i++) begin
         chk_byte("slot_value", mem[io_space_pkg::SLOT_ADDR[i]], slot_value[i]);
      end
   endtask

   task automatic five(input logic m);
      @(posedge ref_clk);
      five_ep_mode <= m;
      repeat (2) @(posedge ref_clk);
      #1;
      chk_flag("func_b_addr_active", !m, b_active);
      chk_byte("func_a_ep3_setup", m ? mem[8'h42] : 8'h00, ep3);
      chk_byte("func_a_ep4_setup", m ? mem[8'h44] : 8'h00, ep4);
   endtask

   task automatic close_out();
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // --------------------
   // clock, timeout, sequence
   // --------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // the whole run needs about 15200 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      int n;
      logic [7:0] l0;
      logic [7:0] h0;
      logic [7:0] l1;
      logic [11:0] dt;
      rst_n = 1'b0;
      irq_vector = 8'h00;
      five_ep_mode = 1'b0;
      hub_lines = '0;
      for (int a = 0; a < 256; a++) begin
         mem[a] = 8'h00;
      end
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      sweep();
      u_core_io_model.rsvd_ok = 1'b1;
      for (int a = 0; a < 256; a++) begin
         wr(1'b0, a[7:0], 8'h00);
      end
      sweep();
      for (int i = 0; i < 48; i++) begin
         seed = lfsr(seed);
         wr(1'b1, (i < 8) ? 8'h00 : seed[15:8], seed[7:0]);
      end
      u_core_io_model.rsvd_ok = 1'b0;
      sweep();
      five(1'b1);
      five(1'b0);
      rd(8'h24);
      l0 = q;
      n = cyc;
      rd(8'h25);
      h0 = q;
      chk_byte("timer_high_pad", 8'h00, {h0[7:4], 4'h0});
      repeat (13000) @(posedge ref_clk);
      rd(8'h25);
      chk_byte("timer_high_latch", h0, q);
      rd(8'h24);
      l1 = q;
      n = (cyc - n) / 50;
      rd(8'h25);
      dt = {q[3:0], l1} - {h0[3:0], l0};
      chk_flag("timer_rate", 1'b1, (int'(dt) >= n - 1) && (int'(dt) <= n + 1));
      close_out();
   end
endmodule
`default_nettype wire
